// [design/eep_pkg.sv]
// Purpose: shared constants and types of the two-wire memory slave
// Assumes: core clock of 100 MHz
// Notes:   the storage array sits outside and is reached by ports
//
// Summary of operation
// RQ1: start is SDA falling with SCL high; stop is SDA rising with SCL high.
// RQ2: SDA changes only while SCL low; SDA is sampled while SCL high.
// RQ3: drive acknowledge low from eighth clock fall through ninth clock, when selected.
// RQ4: release SDA during the ninth clock of a read byte.
// RQ5: master sends three bytes plus acknowledge clocks; reads need nine more clocks.
// RQ6: selected only when select bits equal the three strap levels.
// RQ7: programming starts only on stop after full 27-clock write sequence.
// RQ8: matching write select during programming aborts the programming.
// RQ9: read select during programming is ignored and not acknowledged.
// RQ10: write select, address, repeated start, read select enters reading.
// RQ11: load addressed word on ninth clock; first bit after its falling edge.
// RQ12: one bit per clock; address increments only on master acknowledge low.
// RQ13: address counter wraps from the last location back to zero.
// RQ14: stop releases SDA and returns sequence control to idle.
// RQ15: programming erases word to all ones, then clears the zero data bits.
// RQ16: erase and write finish within 20 ms, typically 10 ms.
// RQ17: skip write when data has no zeros; skip erase when word erased.
// RQ18: SDA released after power-up; power-on period rejects programming.
// RQ19: master should first perform a read sequence with a word address.
// RQ20: stop after write to address 0 of FF with strap 2 floating erases all.
// RQ21: master returns the floated strap to a defined level after total erase.
// RQ22: strap 0 floating blocks all programming and requires select bit 0 zero.
// RQ23: bytes travel most significant bit first.
// RQ24: select word is type code, three select bits, then direction bit.
// RQ25: unmatched select leaves SDA released until next start or stop.
// RQ26: master leaving acknowledge high ends the read; device waits for stop.
package eep_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TYP_MS   = 10;
  localparam int PROG_MAX_MS   = 20;
  localparam int PHASE_CYC     = PROG_TYP_MS * 1_000_000 / CLK_PERIOD_NS / 2;
  localparam int POR_TIME_US   = 100;
  localparam int POR_CYC       = POR_TIME_US * 1_000 / CLK_PERIOD_NS;
  localparam int TMR_W         = 24;

  // select word type code, value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h6;
  localparam int SEL_TYPE_HI = 7;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_CS2     = 3;
  localparam int SEL_CS1     = 2;
  localparam int SEL_CS0     = 1;
  localparam int SEL_DIR     = 0;

  localparam logic [3:0] BIT_ZERO  = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h8;
  localparam logic [3:0] BIT_ACK   = 4'h9;
  localparam logic [3:0] BIT_STEP  = 4'h1;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam logic [7:0] DATA_ONES = 8'hff;

  localparam int SYNC_BITS = 8;
  localparam logic [SYNC_BITS-1:0] SYNC_RST = 8'h03;
  localparam int IX_SCL = 0;
  localparam int IX_SDA = 1;
  localparam int IX_S0  = 2;
  localparam int IX_S1  = 3;
  localparam int IX_S2  = 4;
  localparam int IX_F0  = 5;
  localparam int IX_F2  = 7;

  localparam int BUF_DEPTH = 2;
  localparam int CMD_W     = 19;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_WADDR, ST_WDATA, ST_WDONE, ST_RLOAD, ST_READ, ST_IGNORE
  } eep_bus_e;

  typedef enum logic [1:0] {PG_IDLE, PG_ERASE, PG_WRITE, PG_PUSH} eep_prog_e;
endpackage

// [design/eep_buf2.sv]
// Purpose: two-entry command buffer toward the storage array
// Assumes: one clock, synchronous reset
// Notes:   full and empty come from flops
`timescale 1ns/1ps
`default_nettype none
module eep_buf2
  import eep_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [CMD_W-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [CMD_W-1:0] out_data
);
  logic [CMD_W-1:0] mem_r [BUF_DEPTH];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  logic [1:0]       cnt_nxt;
  logic             in_ready_r;
  logic             out_valid_r;
  wire              push = in_valid & in_ready_r;
  wire              pop  = out_valid_r & out_ready;

  assign cnt_nxt   = cnt_r + {1'b0, push} - {1'b0, pop};
  assign in_ready  = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_r        <= 1'b0;
      rp_r        <= 1'b0;
      cnt_r       <= 2'h0;
      in_ready_r  <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      wp_r        <= wp_r ^ push;
      rp_r        <= rp_r ^ pop;
      cnt_r       <= cnt_nxt;
      in_ready_r  <= cnt_nxt != 2'(BUF_DEPTH);
      out_valid_r <= cnt_nxt != 2'h0;
    end
  end
endmodule
`default_nettype wire

// [design/eep_slave.sv]
// Purpose: two-wire slave front end and programming control, 256 x 8 memory
// Assumes: SCL and SDA sampled by core_clk; array read data valid 2 cycles after rd_addr
// Notes:   wr_* carries finished programming commands to the array
`timescale 1ns/1ps
`default_nettype none
module eep_slave
  import eep_pkg::*;
#(
  parameter int PHASE_CYCLES = PHASE_CYC,
  parameter int POR_CYCLES   = POR_CYC
)(
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       select_strap_bit0,
  input  wire logic       select_strap_bit1,
  input  wire logic       select_strap_bit2,
  input  wire logic       select_strap_bit0_float,
  input  wire logic       select_strap_bit1_float,
  input  wire logic       select_strap_bit2_float,
  output logic      [7:0] rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            prog_busy,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic            wr_all,
  output logic            wr_erase,
  output logic            wr_write,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [SYNC_BITS-1:0] pin_vec = {select_strap_bit2_float, select_strap_bit1_float,
                                  select_strap_bit0_float, select_strap_bit2,
                                  select_strap_bit1, select_strap_bit0, sda_in, scl_in};
  wire [SYNC_BITS-1:0] filt;

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_BITS; gi++) begin : g_sync
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic f_r;
      assign filt[gi] = f_r;
      always_ff @(posedge core_clk) begin
        if (srst) begin
          s1_r <= SYNC_RST[gi];
          s2_r <= SYNC_RST[gi];
          s3_r <= SYNC_RST[gi];
          f_r  <= SYNC_RST[gi];
        end else begin
          s1_r <= pin_vec[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            f_r <= s3_r;
          end
        end
      end
    end
  endgenerate

  wire scl_f   = filt[IX_SCL];
  wire sda_f   = filt[IX_SDA];
  wire strap0  = filt[IX_S0];
  wire strap1  = filt[IX_S1];
  wire strap2  = filt[IX_S2];
  wire protect = filt[IX_F0];
  wire float2  = filt[IX_F2];

  // ------------------------------------------------------------
  // bus events
  // ------------------------------------------------------------
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_d_r <= SYNC_RST[IX_SCL];
      sda_d_r <= SYNC_RST[IX_SDA];
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_d_r;
  wire scl_fall  = ~scl_f & scl_d_r;
  // RQ1 start stop
  wire start_det = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire stop_det  = scl_f & scl_d_r & ~sda_d_r & sda_f;

  // ------------------------------------------------------------
  // byte handling
  // ------------------------------------------------------------
  eep_bus_e   st_r;
  eep_bus_e   st_nxt;
  eep_prog_e  pg_r;
  eep_prog_e  pg_nxt;
  logic [3:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] addr_r;
  logic [7:0] data_r;
  logic       sda_oe_r;
  logic       sda_oe_nxt;
  logic       sda_out_r;
  logic       prog_busy_r;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] por_r;
  logic       all_r;
  logic       er_r;
  logic       wrf_r;
  logic [7:0] paddr_r;
  logic [7:0] pdata_r;

  wire busy     = prog_busy_r;
  wire por_on   = por_r != TMR_W'(0);
  wire byte_end = scl_fall && cnt_r == BIT_LAST;
  wire ack_end  = scl_fall && cnt_r == BIT_ACK;
  wire ack_rise = scl_rise && cnt_r == BIT_LAST;
  wire bit_fall = scl_fall && cnt_r != BIT_ZERO && cnt_r < BIT_LAST;

  // RQ24 select layout
  wire type_ok = rx_r[SEL_TYPE_HI:SEL_TYPE_LO] == TYPE_CODE;
  wire dir_rd  = rx_r[SEL_DIR];
  // RQ6 strap match
  wire cs_hi   = rx_r[SEL_CS2] == strap2 && rx_r[SEL_CS1] == strap1;
  // RQ22 protect select
  wire cs_lo   = protect ? !rx_r[SEL_CS0] : rx_r[SEL_CS0] == strap0;
  wire match   = type_ok && cs_hi && cs_lo;

  wire in_sel    = st_r == ST_SEL;
  wire wr_sel_ok = in_sel && match && !dir_rd;
  // RQ9 poll while busy
  wire rd_sel_ok = in_sel && match && dir_rd && !busy;
  // RQ8 abort on write select
  wire abort     = byte_end && wr_sel_ok && busy;
  wire want_ack  = wr_sel_ok || rd_sel_ok || st_r == ST_WADDR || st_r == ST_WDATA;
  wire m_ack     = ack_rise && st_r == ST_READ && !sda_f;
  wire m_nack    = ack_rise && st_r == ST_READ && sda_f;
  wire [7:0] tx_src = (st_r == ST_RLOAD) ? tx_r : rd_data;

  // RQ7 stop after data
  wire prog_req   = stop_det && st_r == ST_WDONE && !protect && !por_on;
  // RQ20 total erase
  wire all_req    = prog_req && addr_r == ADDR_ZERO && data_r == DATA_ONES && float2;
  // RQ17 skip phases
  wire need_erase = all_req || rd_data != DATA_ONES;
  wire need_write = !all_req && data_r != DATA_ONES;
  wire tmr_done   = tmr_r == TMR_W'(0);
  wire push_rdy;
  wire [CMD_W-1:0] buf_out;

  // RQ10 read entry
  always_comb begin
    st_nxt = st_r;
    if (start_det) begin
      st_nxt = ST_SEL;
    end else if (stop_det) begin
      // RQ14 idle on stop
      st_nxt = ST_IDLE;
    end else if (byte_end) begin
      case (st_r)
        ST_SEL:   st_nxt = wr_sel_ok ? ST_WADDR : (rd_sel_ok ? ST_RLOAD : ST_IGNORE);
        ST_WADDR: st_nxt = ST_WDATA;
        ST_WDATA: st_nxt = ST_WDONE;
        ST_WDONE: st_nxt = ST_IGNORE;
        default:  st_nxt = st_r;
      endcase
    end else if (m_nack) begin
      // RQ26 end read
      st_nxt = ST_IGNORE;
    end else if (ack_end && st_r == ST_RLOAD) begin
      st_nxt = ST_READ;
    end
  end

  always_comb begin
    sda_oe_nxt = sda_oe_r;
    if (start_det || stop_det) begin
      sda_oe_nxt = 1'b0;
    end else if (byte_end) begin
      // RQ3 acknowledge, RQ4 read release, RQ25 silent
      sda_oe_nxt = want_ack && st_r != ST_READ;
    end else if (ack_end) begin
      // RQ11 first bit
      sda_oe_nxt = (st_r == ST_RLOAD || st_r == ST_READ) && !tx_src[7];
    end else if (bit_fall && st_r == ST_READ) begin
      // RQ23 msb first
      sda_oe_nxt = !tx_r[6];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r      <= ST_IDLE;
      cnt_r     <= BIT_ZERO;
      sda_oe_r  <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      sda_oe_r  <= sda_oe_nxt;
      sda_out_r <= 1'b0;
      if (start_det || ack_end) begin
        cnt_r <= BIT_ZERO;
      end else if (scl_rise && cnt_r < BIT_ACK) begin
        cnt_r <= cnt_r + BIT_STEP;
      end
    end
  end

  // RQ2 sample while high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_r <= ADDR_ZERO;
    end else if (scl_rise && cnt_r < BIT_LAST) begin
      rx_r <= {rx_r[6:0], sda_f};
    end
  end

  // RQ12 shift one bit per clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_r <= DATA_ONES;
    end else if (ack_rise && st_r == ST_RLOAD) begin
      tx_r <= rd_data;
    end else if (ack_end) begin
      tx_r <= tx_src;
    end else if (bit_fall && st_r == ST_READ) begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_r <= ADDR_ZERO;
      data_r <= DATA_ONES;
    end else if (byte_end && st_r == ST_WADDR) begin
      addr_r <= rx_r;
    end else if (byte_end && st_r == ST_WDATA) begin
      data_r <= rx_r;
    end else if (m_ack) begin
      // RQ13 wrap to zero
      addr_r <= addr_r + ADDR_STEP;
    end
  end

  // ------------------------------------------------------------
  // self-timed programming
  // ------------------------------------------------------------
  // RQ16 phase timing
  always_comb begin
    pg_nxt = pg_r;
    if (abort) begin
      pg_nxt = PG_IDLE;
    end else begin
      case (pg_r)
        PG_IDLE: begin
          if (prog_req && need_erase) begin
            pg_nxt = PG_ERASE;
          end else if (prog_req && need_write) begin
            pg_nxt = PG_WRITE;
          end
        end
        PG_ERASE: begin
          if (tmr_done) begin
            pg_nxt = wrf_r ? PG_WRITE : PG_PUSH;
          end
        end
        PG_WRITE: begin
          if (tmr_done) begin
            pg_nxt = PG_PUSH;
          end
        end
        PG_PUSH: begin
          if (push_rdy) begin
            pg_nxt = PG_IDLE;
          end
        end
        default: pg_nxt = PG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pg_r        <= PG_IDLE;
      prog_busy_r <= 1'b0;
      tmr_r       <= TMR_W'(0);
    end else begin
      pg_r        <= pg_nxt;
      prog_busy_r <= pg_nxt != PG_IDLE;
      if (pg_nxt != pg_r) begin
        tmr_r <= TMR_W'(PHASE_CYCLES - 1);
      end else if (!tmr_done) begin
        tmr_r <= tmr_r - TMR_W'(1);
      end
    end
  end

  // RQ15 erase then write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      all_r   <= 1'b0;
      er_r    <= 1'b0;
      wrf_r   <= 1'b0;
      paddr_r <= ADDR_ZERO;
      pdata_r <= DATA_ONES;
    end else if (prog_req && pg_r == PG_IDLE) begin
      all_r   <= all_req;
      er_r    <= need_erase;
      wrf_r   <= need_write;
      paddr_r <= addr_r;
      pdata_r <= data_r;
    end
  end

  // RQ18 power-on hold-off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      por_r <= TMR_W'(POR_CYCLES);
    end else if (por_on) begin
      por_r <= por_r - TMR_W'(1);
    end
  end

  eep_buf2 u_buf (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (pg_r == PG_PUSH),
    .in_ready  (push_rdy),
    .in_data   ({all_r, er_r, wrf_r, paddr_r, pdata_r}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (buf_out)
  );

  assign {wr_all, wr_erase, wr_write, wr_addr, wr_data} = buf_out;
  assign sda_out   = sda_out_r;
  assign sda_oe    = sda_oe_r;
  assign rd_addr   = addr_r;
  assign prog_busy = prog_busy_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  stop_release_a: assert property (stop_det |=> !sda_oe_r && st_r == ST_IDLE) // RQ14
    else $error("stop did not release the bus");
  ack_drive_a: assert property (byte_end && wr_sel_ok |=> sda_oe_r) // RQ3
    else $error("matching select not acknowledged");
  no_match_a: assert property (byte_end && in_sel && !match |=> !sda_oe_r) // RQ6
    else $error("unmatched select acknowledged");
  poll_busy_a: assert property (byte_end && in_sel && dir_rd && busy |=> !sda_oe_r) // RQ9
    else $error("read select acknowledged while busy");
  abort_prog_a: assert property (abort |=> !prog_busy_r && pg_r == PG_IDLE) // RQ8
    else $error("write select did not abort programming");
  addr_wrap_a: assert property (m_ack && addr_r == DATA_ONES |=> addr_r == ADDR_ZERO) // RQ13
    else $error("address did not wrap");
  read_rel_a: assert property (byte_end && st_r == ST_READ |=> !sda_oe_r [*2]) // RQ4
    else $error("data not released for master acknowledge");
  prog_start_a: assert property (prog_req && !abort && (need_erase || need_write) // RQ7
    |=> prog_busy_r)
    else $error("stop after data did not start programming");
  protect_a: assert property (stop_det && protect && !prog_busy_r |=> !prog_busy_r) // RQ22
    else $error("programming while protected");
  por_block_a: assert property (stop_det && por_on && !prog_busy_r |=> !prog_busy_r) // RQ18
    else $error("programming during power-on period");
endmodule
`default_nettype wire

// [tb/eep_master.sv]
// Purpose: two-wire bus master model for the slave link
// Assumes: bench resolves the pulled-up SDA wire from all enables
// Notes:   SCL stands high between frames; steps on core_clk falls
`timescale 1ns/1ps
`default_nettype none
module eep_master #(
  parameter int Q = 6
)(
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic q();
    repeat (Q) @(negedge core_clk);
  endtask

  task automatic start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  // data moves only while SCL low
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    s = sda_line;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~mack, s);
  endtask

  task automatic stop();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask
endmodule
`default_nettype wire

// [tb/eep_slave_bench.sv]
// Purpose: self-checking bench of the two-wire memory slave
// Assumes: array model answers rd_addr two cycles later
// Notes:   wr_ready stalls at random; stall forces a full buffer
`timescale 1ns/1ps
`default_nettype none
module eep_slave_bench;
  import eep_pkg::*;
  localparam int LIMIT = 60_000;
  logic       core_clk, srst, scl_in, sda_in, sda_out, sda_oe, sda_rel, stall;
  logic       prog_busy, wr_valid, wr_ready, wr_all, wr_erase, wr_write, k;
  logic [2:0] sv, fl, cs;
  logic [7:0] rd_addr, rd_data, rd_p, wr_addr, wr_data, a, d, pv;
  logic [7:0] mem [256];
  logic [7:0] ex  [256];
  int         n_errors, n_checks, cyc, seed, rb, n;

  eep_slave #(.PHASE_CYCLES(400), .POR_CYCLES(800)) u_eep_slave (
    .core_clk(core_clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_strap_bit0(sv[0]),
    .select_strap_bit1(sv[1]), .select_strap_bit2(sv[2]),
    .select_strap_bit0_float(fl[0]), .select_strap_bit1_float(fl[1]),
    .select_strap_bit2_float(fl[2]), .rd_addr(rd_addr), .rd_data(rd_data),
    .prog_busy(prog_busy), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_all(wr_all),
    .wr_erase(wr_erase), .wr_write(wr_write), .wr_addr(wr_addr), .wr_data(wr_data));
  eep_master u_eep_master (.core_clk(core_clk), .sda_line(sda_in), .scl(scl_in),
    .sda_rel(sda_rel));
  // pulled-up open-drain wire
  assign sda_in = sda_rel & (sda_oe ? sda_out : 1'b1);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    rd_p    <= mem[rd_addr];
    rd_data <= rd_p;
    if (wr_valid && wr_ready) begin
      if (wr_all) for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
      else mem[wr_addr] <= (wr_erase ? 8'hff : mem[wr_addr]) & (wr_write ? wr_data : 8'hff);
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      conclude();
    end
  end

  always @(negedge core_clk) begin
    rb = $random(seed);
    wr_ready <= ~stall & rb[0];
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] sw(input logic [2:0] c, input logic dir);
    return {TYPE_CODE, c, dir};
  endfunction

  task automatic wt();
    n = 0;
    while (prog_busy !== 1'b0 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  task automatic wr(input logic [7:0] wa, input logic [7:0] wd, input logic te);
    u_eep_master.start();
    u_eep_master.wbyte(sw(cs, 1'b0), k);
    chk("ack select", k, 1'b1);
    u_eep_master.wbyte(wa, k);
    chk("ack address", k, 1'b1);
    u_eep_master.wbyte(wd, k);
    chk("ack data", k, 1'b1);
    fl[2] = te;
    u_eep_master.stop();
    repeat (10) @(negedge core_clk);
  endtask

  task automatic probe(input logic [7:0] w, input logic ackx);
    u_eep_master.start();
    u_eep_master.wbyte(w, k);
    chk("probe ack", k, ackx);
    if (k && w[0]) u_eep_master.rbyte(1'b0, pv);
    u_eep_master.stop();
  endtask

  task automatic rd(input logic [7:0] ra, input int cnt);
    u_eep_master.start();
    u_eep_master.wbyte(sw(cs, 1'b0), k);
    u_eep_master.wbyte(ra, k);
    u_eep_master.start();
    u_eep_master.wbyte(sw(cs, 1'b1), k);
    chk("ack read select", k, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      u_eep_master.rbyte(i < cnt - 1, d);
      chk("read data", d, ex[8'(ra + i)]);
    end
    u_eep_master.bit_io(1'b1, k);
    chk("silent after nack", k, 1'b1);
    u_eep_master.stop();
    chk("released at stop", sda_oe, 1'b0);
  endtask

  initial begin
    seed = 65941;
    srst = 1'b1;
    stall = 1'b0;
    wr_ready = 1'b0;
    rd_data = 8'h00;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    fl = 3'h0;
    sv = 3'($random(seed));
    cs = sv;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      ex[i] = mem[i];
    end
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    chk("oe after reset", sda_oe, 1'b0);
    chk("busy after reset", prog_busy, 1'b0);
    repeat (6) @(negedge core_clk);
    rd(8'($random(seed)), 2);
    rd(8'hff, 3);
    $display("test read and wrap done");
    repeat (4) begin
      a = 8'($random(seed));
      d = 8'($random(seed)) & 8'hfe;
      wr(a, d, 1'b0);
      chk("busy after stop", prog_busy, 1'b1);
      probe(sw(cs, 1'b1), 1'b0);
      wt();
      chk("busy end", prog_busy, 1'b0);
      probe(sw(cs, 1'b1), 1'b1);
      chk("poll read data", pv, d);
      ex[a] = d;
      rd(a, 2);
    end
    $display("test write and poll done");
    for (int x = 1; x < 8; x++) probe(sw(cs ^ 3'(x), 1'b0), 1'b0);
    probe({~TYPE_CODE, cs, 1'b0}, 1'b0);
    probe(sw(cs, 1'b0), 1'b1);
    chk("no program on short write", prog_busy, 1'b0);
    $display("test selection done");
    a = 8'($random(seed));
    wr(a, 8'($random(seed)) & 8'h7f, 1'b0);
    probe(sw(cs, 1'b0), 1'b1);
    chk("busy after abort", prog_busy, 1'b0);
    rd(a, 1);
    $display("test abort done");
    wr(8'h00, 8'hff, 1'b1);
    chk("total erase busy", prog_busy, 1'b1);
    wt();
    fl[2] = 1'b0;
    for (int i = 0; i < 256; i++) ex[i] = 8'hff;
    rd(8'($random(seed)), 2);
    wr(a, 8'hff, 1'b0);
    chk("nothing to program", prog_busy, 1'b0);
    wr(a, 8'hfe, 1'b0);
    wt();
    chk("write phase only", n < 500, 1'b1);
    ex[a] = 8'hfe;
    rd(a, 1);
    $display("test erase paths done");
    fl[0] = 1'b1;
    cs = {sv[2:1], 1'b0};
    wr(a, 8'h00, 1'b0);
    chk("protected busy", prog_busy, 1'b0);
    probe(sw(cs | 3'h1, 1'b0), 1'b0);
    rd(a, 1);
    fl[0] = 1'b0;
    cs = sv;
    $display("test protect done");
    stall = 1'b1;
    for (int j = 0; j < 3; j++) begin
      d = 8'($random(seed)) & 8'hef;
      wr(8'(a + j * 16), d, 1'b0);
      ex[8'(a + j * 16)] = d;
      if (j < 2) wt();
    end
    repeat (1200) @(negedge core_clk);
    chk("held by full buffer", prog_busy, 1'b1);
    stall = 1'b0;
    wt();
    chk("drained", prog_busy, 1'b0);
    for (int j = 0; j < 3; j++) rd(8'(a + j * 16), 1);
    $display("test buffer done");
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    chk("oe after second reset", sda_oe, 1'b0);
    repeat (6) @(negedge core_clk);
    wr(a, 8'h00, 1'b0);
    chk("power-on refusal", prog_busy, 1'b0);
    rd(a, 1);
    $display("test power-on done");
    conclude();
  end
endmodule
`default_nettype wire
